// File: hdl/ffsu_pkg_classify.sv
`timescale 1ns/100ps
package ffsu_pkg;
	// status word bit positions
	localparam int unsigned ST_ERR = 15;
	localparam int unsigned ST_GRP_DIS = 14;
	localparam int unsigned ST_UV_EN = 11;
	localparam int unsigned ST_UNF_EN = 10;
	localparam int unsigned ST_OVF_EN = 9;
	localparam int unsigned ST_CONV_EN = 8;
	localparam int unsigned ST_DBL = 7;
	localparam int unsigned ST_LONG = 6;
	localparam int unsigned ST_CHOP = 5;
	localparam int unsigned ST_N = 3;
	localparam int unsigned ST_Z = 2;
	localparam int unsigned ST_V = 1;
	localparam int unsigned ST_C = 0;
	// meaningful status bits, reserved bits 13, 12 and 4 read zero
	localparam logic [15:0] ST_MASK = 16'hcfef;
	localparam logic [15:0] ST_RESET = 16'h0000;
	// exception codes
	localparam logic [3:0] EC_NONE = 4'h0;
	localparam logic [3:0] EC_OPCODE = 4'h2;
	localparam logic [3:0] EC_DIV_ZERO = 4'h4;
	localparam logic [3:0] EC_CONV = 4'h6;
	localparam logic [3:0] EC_OVF = 4'h8;
	localparam logic [3:0] EC_UNF = 4'ha;
	localparam logic [3:0] EC_UNDEF = 4'hc;
	// exponent bias and true exponent limits
	localparam logic [7:0] EXP_BIAS = 8'h80;
	localparam logic signed [9:0] EXP_TRUE_MAX = 10'sh07f;
	localparam logic signed [9:0] EXP_TRUE_MIN = -10'sh07f;
	// word field layout, single operands sit in the upper half
	localparam int unsigned W_SIGN = 63;
	localparam int unsigned W_EXP_HI = 62;
	localparam int unsigned W_EXP_LO = 55;
	localparam int unsigned FRAC_DBL_W = 55;
	localparam int unsigned FRAC_SGL_W = 23;
	localparam int unsigned INT_SHORT_W = 16;
endpackage : ffsu_pkg

// splits a stored word into its fields and classifies it
module ffsu_classify (
	input wire logic [63:0] word_i,
	input wire logic double_i,
	output logic clean_zero_o,
	output logic dirty_zero_o,
	output logic undef_var_o,
	output logic negative_o,
	output logic is_zero_o,
	output logic [7:0] biased_exp_o,
	output logic [55:0] fraction_o
);
	logic [54:0] frac_field;

	// single mode ignores the low half of the word
	always_comb begin
		frac_field = word_i[54:0];
		if (!double_i) begin
			frac_field[31:0] = 32'h00000000;
		end
	end

	// field split and zero class
	assign biased_exp_o = word_i[ffsu_pkg::W_EXP_HI:ffsu_pkg::W_EXP_LO];
	assign negative_o = word_i[ffsu_pkg::W_SIGN];
	assign is_zero_o = (biased_exp_o == 8'h00);
	assign clean_zero_o = is_zero_o && !negative_o && (frac_field == 55'h0);
	assign dirty_zero_o = is_zero_o && (frac_field != 55'h0);
	assign undef_var_o = is_zero_o && negative_o;
	// hidden bit restored, zero class yields an exact zero fraction
	assign fraction_o = is_zero_o ? 56'h0 : {1'b1, frac_field};
endmodule : ffsu_classify

// File: hdl/ffsu_status_unit.sv
`timescale 1ns/100ps
module ffsu_status_unit (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic load_fp_status_instr_i,
	input wire logic [15:0] status_wdata_i,
	input wire logic op_done_i,
	input wire logic res_sign_i,
	input wire logic res_zero_i,
	input wire logic [9:0] res_exp_i,
	input wire logic [54:0] res_frac_i,
	input wire logic res_carry_i,
	input wire logic mem_operand_valid_i,
	input wire logic [63:0] mem_operand_i,
	input wire logic div_zero_i,
	input wire logic illegal_op_i,
	input wire logic conv_fail_i,
	input wire logic [31:0] int_operand_i,
	output logic [15:0] fp_status_control_o,
	output logic [3:0] fp_exception_code_o,
	output logic exception_req_o,
	output logic result_valid_o,
	output logic [63:0] result_word_o,
	output logic [31:0] int_value_o,
	output logic [55:0] operand_fraction_o,
	output logic operand_zero_o,
	output logic operand_undef_o
);
	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic [3:0] code_reg;
	logic [3:0] code_next;
	logic req_reg;
	logic req_next;
	logic res_valid_reg;
	logic res_valid_next;
	logic [63:0] res_word_reg;
	logic [63:0] res_word_next;
	logic [31:0] int_reg;
	logic [31:0] int_next;
	logic [55:0] opf_reg;
	logic [55:0] opf_next;
	logic opz_reg;
	logic opz_next;
	logic opu_reg;
	logic opu_next;
	logic cls_clean;
	logic cls_dirty;
	logic cls_undef;
	logic cls_neg;
	logic cls_zero;
	logic [7:0] cls_exp;
	logic [55:0] cls_frac;
	logic ovf_det;
	logic unf_det;
	logic uv_det;
	logic q_uv;
	logic q_ovf;
	logic q_unf;
	logic q_conv;
	logic any_q;
	logic store_zero;
	logic [63:0] packed_res;

	// packs sign, true exponent and fraction into a stored word
	function automatic logic [63:0] pack_word(input logic sign, input logic [9:0] texp,
			input logic [54:0] frac, input logic dbl);
		logic [7:0] bexp;
		logic [54:0] f;
		bexp = texp[7:0] + ffsu_pkg::EXP_BIAS;
		f = frac;
		if (!dbl) begin
			f[31:0] = 32'h00000000;
		end
		pack_word = {sign, bexp, f};
	endfunction : pack_word

	// memory operand classification
	ffsu_classify u_classify (
		.word_i(mem_operand_i),
		.double_i(status_reg[ffsu_pkg::ST_DBL]),
		.clean_zero_o(cls_clean),
		.dirty_zero_o(cls_dirty),
		.undef_var_o(cls_undef),
		.negative_o(cls_neg),
		.is_zero_o(cls_zero),
		.biased_exp_o(cls_exp),
		.fraction_o(cls_frac)
	);

	// range checks and qualified exceptions
	assign ovf_det = !res_zero_i && ($signed(res_exp_i) > ffsu_pkg::EXP_TRUE_MAX);
	assign unf_det = !res_zero_i && ($signed(res_exp_i) < ffsu_pkg::EXP_TRUE_MIN);
	assign uv_det = mem_operand_valid_i && cls_undef;
	assign q_uv = uv_det && status_reg[ffsu_pkg::ST_UV_EN];
	assign q_ovf = ovf_det && status_reg[ffsu_pkg::ST_OVF_EN];
	assign q_unf = unf_det && status_reg[ffsu_pkg::ST_UNF_EN];
	assign q_conv = conv_fail_i && status_reg[ffsu_pkg::ST_CONV_EN];
	assign any_q = illegal_op_i || div_zero_i || q_uv || q_ovf || q_unf || q_conv;
	// out of range with its interrupt off stores an exact zero
	assign store_zero = res_zero_i || (ovf_det && !status_reg[ffsu_pkg::ST_OVF_EN]) ||
		(unf_det && !status_reg[ffsu_pkg::ST_UNF_EN]);
	assign packed_res = store_zero ? 64'h0 :
		pack_word(res_sign_i, res_exp_i, res_frac_i, status_reg[ffsu_pkg::ST_DBL]);

	// status word next value
	always_comb begin
		status_next = status_reg;
		if (load_fp_status_instr_i) begin
			status_next = status_wdata_i & ffsu_pkg::ST_MASK;
		end
		if (op_done_i && !illegal_op_i) begin
			status_next[ffsu_pkg::ST_N] = packed_res[ffsu_pkg::W_SIGN];
			status_next[ffsu_pkg::ST_Z] = store_zero;
			status_next[ffsu_pkg::ST_V] = ovf_det;
			status_next[ffsu_pkg::ST_C] = res_carry_i;
		end
		// set beats a simultaneous clear by load
		if (op_done_i && any_q) begin
			status_next[ffsu_pkg::ST_ERR] = 1'b1;
		end
	end

	// exception code and host request
	always_comb begin
		code_next = code_reg;
		req_next = 1'b0;
		if (op_done_i && any_q) begin
			req_next = !status_reg[ffsu_pkg::ST_GRP_DIS];
			if (illegal_op_i) begin
				code_next = ffsu_pkg::EC_OPCODE;
			end else if (q_uv) begin
				code_next = ffsu_pkg::EC_UNDEF;
			end else if (div_zero_i) begin
				code_next = ffsu_pkg::EC_DIV_ZERO;
			end else if (q_conv) begin
				code_next = ffsu_pkg::EC_CONV;
			end else if (q_ovf) begin
				code_next = ffsu_pkg::EC_OVF;
			end else begin
				code_next = ffsu_pkg::EC_UNF;
			end
		end
	end

	// result, integer and operand outputs
	always_comb begin
		res_valid_next = op_done_i && !illegal_op_i;
		res_word_next = res_word_reg;
		int_next = int_reg;
		opf_next = opf_reg;
		opz_next = opz_reg;
		opu_next = opu_reg;
		if (op_done_i && !illegal_op_i) begin
			res_word_next = packed_res;
			if (conv_fail_i) begin
				int_next = 32'h00000000;
			end else if (status_reg[ffsu_pkg::ST_LONG]) begin
				int_next = int_operand_i;
			end else begin
				int_next = {{16{int_operand_i[ffsu_pkg::INT_SHORT_W-1]}}, int_operand_i[15:0]};
			end
		end
		if (mem_operand_valid_i) begin
			opf_next = cls_frac;
			opz_next = cls_zero;
			opu_next = cls_undef;
		end
	end

	// state registers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_reg <= ffsu_pkg::ST_RESET;
			code_reg <= ffsu_pkg::EC_NONE;
			req_reg <= 1'b0;
			res_valid_reg <= 1'b0;
			res_word_reg <= 64'h0;
			int_reg <= 32'h00000000;
			opf_reg <= 56'h0;
			opz_reg <= 1'b0;
			opu_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			code_reg <= code_next;
			req_reg <= req_next;
			res_valid_reg <= res_valid_next;
			res_word_reg <= res_word_next;
			int_reg <= int_next;
			opf_reg <= opf_next;
			opz_reg <= opz_next;
			opu_reg <= opu_next;
		end
	end

	// outputs straight from flip-flops
	assign fp_status_control_o = status_reg;
	assign fp_exception_code_o = code_reg;
	assign exception_req_o = req_reg;
	assign result_valid_o = res_valid_reg;
	assign result_word_o = res_word_reg;
	assign int_value_o = int_reg;
	assign operand_fraction_o = opf_reg;
	assign operand_zero_o = opz_reg;
	assign operand_undef_o = opu_reg;

	// checks on the status and exception logic
	err_sticky_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		status_reg[15] && !load_fp_status_instr_i |=> status_reg[15])
		else $error("error flag cleared without status load");
	div_sets_err_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && div_zero_i |=> fp_status_control_o[15] && exception_req_o == !$past(status_reg[14]))
		else $error("divide by zero did not set error flag");
	grp_dis_req_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && status_reg[14] |=> !exception_req_o)
		else $error("request raised while group disabled");
	req_needs_err_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		exception_req_o |-> fp_status_control_o[15] && !$past(status_reg[14]))
		else $error("request without error flag");
	opcode_code_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && illegal_op_i |=> fp_exception_code_o == 4'h2 && !result_valid_o)
		else $error("opcode error code wrong");
	ovf_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && ovf_det && !status_reg[9] |=> result_word_o == 64'h0 && status_reg[2])
		else $error("disabled overflow did not store zero");
	no_minus_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && !status_reg[9] && !status_reg[10]
		|=> !(result_word_o[63] && result_word_o[62:55] == 8'h00))
		else $error("minus zero stored with interrupts off");
	ovf_code_v_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && !res_zero_i && $signed(res_exp_i) == 10'sh080 |=> status_reg[1])
		else $error("overflow at 200 octal not flagged");
	wrap_exp_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && !res_zero_i && res_exp_i == 10'h080 && status_reg[9]
		|=> result_word_o[62:55] == 8'h00 && result_word_o[54:32] == $past(res_frac_i[54:32]))
		else $error("overflow result not wrapped");
	cc_neg_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		result_valid_o |-> fp_status_control_o[3] == result_word_o[63])
		else $error("negative code mismatch");
	reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		fp_status_control_o[13:12] == 2'h0 && !fp_status_control_o[4])
		else $error("reserved status bits set");
	int_short_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && !conv_fail_i && !status_reg[6]
		|=> int_value_o == {{16{$past(int_operand_i[15])}}, $past(int_operand_i[15:0])})
		else $error("short integer not sign extended");
	undef_trap_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && uv_det && status_reg[11] && !illegal_op_i |=> fp_exception_code_o == 4'hc)
		else $error("undefined variable code wrong");

	code_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !any_q |=> fp_exception_code_o == $past(code_reg))
		else $error("exception code changed without exception");
	load_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		load_fp_status_instr_i && !op_done_i
		|=> fp_status_control_o == ($past(status_wdata_i) & ffsu_pkg::ST_MASK))
		else $error("status load not taken");
	pulse_only_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!op_done_i |=> !exception_req_o && !result_valid_o)
		else $error("pulse without finished instruction");
	unf_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && !illegal_op_i && unf_det && !status_reg[ffsu_pkg::ST_UNF_EN]
		|=> result_word_o == 64'h0 && fp_status_control_o[ffsu_pkg::ST_Z])
		else $error("disabled underflow did not store zero");
	clean_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		mem_operand_valid_i && cls_clean |=> operand_zero_o && !operand_undef_o && operand_fraction_o == 56'h0)
		else $error("clean zero not classed as zero");
	dirty_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		mem_operand_valid_i && cls_dirty |=> operand_zero_o && operand_fraction_o == 56'h0)
		else $error("dirty zero not treated as zero");
	nonzero_exp_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		mem_operand_valid_i && cls_exp != 8'h00 |=> !operand_zero_o && operand_fraction_o[55])
		else $error("nonzero exponent lost hidden bit");
	undef_neg_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		mem_operand_valid_i && cls_neg && cls_zero |=> operand_undef_o)
		else $error("negative zero operand not flagged undefined");

	// main scenarios
	div_seen_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) op_done_i && div_zero_i);
	ovf_int_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) op_done_i && q_ovf);
	undef_int_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) op_done_i && q_uv);
	err_clear_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
		status_reg[15] && load_fp_status_instr_i && !status_wdata_i[15]);
	ovf_wrap_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
		op_done_i && q_ovf && res_exp_i == 10'h080);
endmodule : ffsu_status_unit

// File: testbench/ffsu_host_model.sv
`timescale 1ns/100ps
// host core stand-in: issues floating instructions on the falling edge
module ffsu_host_model (
	input wire logic core_clk_i,
	output logic load_o,
	output logic [15:0] wdata_o,
	output logic op_done_o,
	output logic sign_o,
	output logic zero_o,
	output logic [9:0] exp_o,
	output logic [54:0] frac_o,
	output logic carry_o,
	output logic memv_o,
	output logic [63:0] mem_o,
	output logic div_o,
	output logic ill_o,
	output logic conv_o,
	output logic [31:0] int_o
);
	// idle: no request, data lines carry junk
	initial begin
		{load_o, op_done_o, memv_o, div_o, ill_o, conv_o} = 6'h00;
		{wdata_o, sign_o, zero_o, exp_o, frac_o, carry_o, mem_o, int_o} = '1;
	end
	// one status load cycle
	task automatic load(input logic [15:0] w);
		@(negedge core_clk_i);
		{load_o, op_done_o, memv_o} = 3'h4;
		wdata_o = w;
	endtask : load
	// one finished floating instruction with its causes
	task automatic issue(input logic s, z, input logic [9:0] e, input logic [54:0] fr, input logic c, mv,
			input logic [63:0] m, input logic d, i, f, input logic [31:0] n);
		@(negedge core_clk_i);
		{load_o, op_done_o, memv_o} = {2'h1, mv};
		{sign_o, zero_o, exp_o, frac_o, carry_o} = {s, z, e, fr, c};
		{mem_o, div_o, ill_o, conv_o, int_o} = {m, d, i, f, n};
	endtask : issue
	// release: strobes low, data words inverted, sign, zero and carry kept
	task automatic idle();
		@(negedge core_clk_i);
		{load_o, op_done_o, memv_o, div_o, ill_o, conv_o} = 6'h00;
		{wdata_o, exp_o, frac_o, mem_o, int_o} = ~{wdata_o, exp_o, frac_o, mem_o, int_o};
	endtask : idle
endmodule : ffsu_host_model

// File: testbench/ffsu_status_unit_tb.sv
`timescale 1ns/100ps
`define CHK(a, b, msg) begin \
	checks_done++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("CHECK FAILED at %0t: %s", $time, msg); \
	end \
end
module ffsu_status_unit_tb;
	typedef struct packed {logic [15:0] st; logic [3:0] ec; logic [63:0] w; logic [31:0] iv;
		logic [55:0] of; logic oz, ou;} ffsu_mdl_t;
	typedef struct {int due; logic rq, rv; ffsu_mdl_t m;} ffsu_note_t;
	logic core_clk_i = 1'b0;
	logic arst_n = 1'b0;
	logic h_ld, h_od, h_sg, h_zr, h_cy, h_mv, h_dz, h_il, h_cf;
	logic [15:0] h_wd;
	logic [9:0] h_ex;
	logic [54:0] h_fr;
	logic [63:0] h_mem, rw_o;
	logic [31:0] h_io, iv_o, r;
	logic [15:0] st_o;
	logic [3:0] ec_o;
	logic rq_o, rv_o, oz_o, ou_o;
	logic [55:0] of_o;
	logic [31:0] rs = 32'h00007cea;
	logic [15:0] cfg[3] = '{16'h0000, 16'h0f00, 16'h4fc0};
	logic [9:0] bnd[5] = '{10'h07f, 10'h081, 10'h381, 10'h37f, 10'h000};
	ffsu_mdl_t mdl = '0;
	ffsu_note_t q[$];
	ffsu_note_t got;
	int cyc = 0;
	int num_errors = 0;
	int checks_done = 0;
	ffsu_host_model i_host (.core_clk_i, .load_o(h_ld), .wdata_o(h_wd), .op_done_o(h_od), .sign_o(h_sg),
		.zero_o(h_zr), .exp_o(h_ex), .frac_o(h_fr), .carry_o(h_cy), .memv_o(h_mv), .mem_o(h_mem),
		.div_o(h_dz), .ill_o(h_il), .conv_o(h_cf), .int_o(h_io));
	ffsu_status_unit i_dut (.core_clk_i, .arst_n_i(arst_n), .load_fp_status_instr_i(h_ld),
		.status_wdata_i(h_wd), .op_done_i(h_od), .res_sign_i(h_sg), .res_zero_i(h_zr), .res_exp_i(h_ex),
		.res_frac_i(h_fr), .res_carry_i(h_cy), .mem_operand_valid_i(h_mv), .mem_operand_i(h_mem),
		.div_zero_i(h_dz), .illegal_op_i(h_il), .conv_fail_i(h_cf), .int_operand_i(h_io),
		.fp_status_control_o(st_o), .fp_exception_code_o(ec_o), .exception_req_o(rq_o),
		.result_valid_o(rv_o), .result_word_o(rw_o), .int_value_o(iv_o), .operand_fraction_o(of_o),
		.operand_zero_o(oz_o), .operand_undef_o(ou_o));
	// 40 MHz clock
	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// cycle count for due times
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
	end
	// xorshift source
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// snapshot of the model, due on the next cycle
	task automatic note(input ffsu_note_t t);
		t.due = cyc + 1;
		t.m = mdl;
		q.push_back(t);
	endtask : note
	// status load with expectation
	task automatic ld(input logic [15:0] w);
		ffsu_note_t t;
		i_host.load(w);
		mdl.st = w & 16'hcfef;
		t.rq = 1'b0;
		t.rv = 1'b0;
		note(t);
	endtask : ld
	// floating instruction with expectation
	task automatic op(input logic [9:0] e, input logic z, d, i, f, mv, input logic [63:0] m);
		logic [31:0] r, n;
		logic s, c, ov, un, sz, uv;
		logic [54:0] fr;
		logic [3:0] code;
		ffsu_note_t t;
		r = rnd();
		n = rnd();
		s = r[31];
		c = r[30];
		fr = {r[22:0], mdl.st[7] ? n : 32'h0};
		ov = !z && $signed(e) > 10'sh07f;
		un = !z && $signed(e) < -10'sh07f;
		sz = z || (ov && !mdl.st[9]) || (un && !mdl.st[10]);
		uv = mv && m[63] && m[62:55] == 8'h00;
		code = i ? 4'h2 : (uv && mdl.st[11]) ? 4'hc : d ? 4'h4 : (f && mdl.st[8]) ? 4'h6 :
			(ov && mdl.st[9]) ? 4'h8 : (un && mdl.st[10]) ? 4'ha : 4'h0;
		t.rq = code != 4'h0 && !mdl.st[14];
		t.rv = !i;
		if (code != 4'h0) begin
			mdl.st[15] = 1'b1;
			mdl.ec = code;
		end
		if (!i) begin
			mdl.w = sz ? 64'h0 : {s, e[7:0] + 8'h80, fr};
			mdl.st[3:0] = {s && !sz, sz, ov, c};
			mdl.iv = f ? 32'h0 : mdl.st[6] ? n : {{16{n[15]}}, n[15:0]};
		end
		if (mv) begin
			mdl.oz = m[62:55] == 8'h00;
			mdl.ou = uv;
			mdl.of = mdl.oz ? 56'h0 : {1'b1, m[54:32], mdl.st[7] ? m[31:0] : 32'h0};
		end
		i_host.issue(s, z, e, fr, c, mv, m, d, i, f, n);
		note(t);
	endtask : op
	// compares outputs with the oldest note when it falls due
	always @(negedge core_clk_i) begin
		if (q.size() > 0 && q[0].due == cyc) begin
			got = q.pop_front();
			`CHK(st_o, got.m.st, "status word")
			`CHK(ec_o, got.m.ec, "exception code")
			`CHK({rq_o, rv_o}, {got.rq, got.rv}, "request or valid")
			`CHK(rw_o, got.m.w, "result word")
			`CHK(iv_o, got.m.iv, "integer value")
			`CHK({of_o, oz_o, ou_o}, {got.m.of, got.m.oz, got.m.ou}, "operand class")
		end else if (arst_n) begin
			`CHK({rq_o, rv_o}, 2'h0, "stray pulse")
		end
	end
	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	// watchdog
	initial begin
		#(25 * 4000);
		num_errors++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		arst_n = 1'b1;
		`CHK({st_o, ec_o}, 20'h00000, "reset state")
		ld(16'hffff);
		ld(16'h0000);
		i_host.idle();
		$display("load test done");
		// each exception with enables off, on, then group disabled
		foreach (cfg[k]) begin
			ld(cfg[k]);
			for (int j = 0; j < 6; j++) begin
				r = rnd();
				op(j == 3 ? 10'h080 : j == 4 ? 10'h380 : {3'h0, r[6:0]} - 10'h020, 1'b0, j == 1, j == 0,
					j == 2, 1'b1, {j == 5 || r[8], j == 5 ? 8'h00 : 8'h41 | r[7:0], r[31:9], rnd()});
			end
			ld(16'h0000);
		end
		i_host.idle();
		$display("exception test done");
		// exponent limits and operand zero kinds, error flag sticky
		ld(16'h0780);
		foreach (bnd[k]) begin
			r = rnd();
			op(bnd[k], k == 4, 1'b0, 1'b0, 1'b0, k != 2,
				k == 0 ? 64'h0 : {1'b0, k == 1 ? 8'h00 : r[7:0] | 8'h01, r[31:9], rnd()});
		end
		ld(16'h0000);
		i_host.idle();
		repeat (3) @(negedge core_clk_i);
		`CHK(q.size(), 0, "notes left over")
		$display("limit test done");
		close_out();
	end
endmodule : ffsu_status_unit_tb
